// *** design/readout_ctl_pkg.sv ***
`default_nettype none
// ============================================================
// shared constants and types of the read-out control block
package readout_ctl_pkg;

  // ============================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS     = 5;
  localparam int unsigned BUF_RESET_LIMIT_NS = 1_000_000;
  // strictly less than the limit, so one cycle short of it
  localparam int unsigned BUF_RESET_MAX_CYC =
    BUF_RESET_LIMIT_NS / CLK_PERIOD_NS - 1;

  // ============================================================
  // register byte offsets
  localparam logic [7:0] OFS_THRESH    = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_EVENT_NUM = 8'h08;
  localparam logic [7:0] OFS_TALLY     = 8'h0C;
  localparam logic [7:0] OFS_RST_DELAY = 8'h10;
  localparam logic [7:0] OFS_ROI_LIMIT = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;
  localparam logic [7:0] OFS_FRAME_CFG = 8'h20;
  localparam logic [7:0] OFS_FRAME_LEN = 8'h24;

  // ============================================================
  // status and interrupt bit positions (same layout)
  localparam int unsigned BIT_BUSY  = 0;
  localparam int unsigned BIT_LOSS  = 1;
  localparam int unsigned BIT_TRUNC = 2;
  localparam int unsigned BIT_CLEAR = 3;
  localparam int unsigned IRQ_W     = 4;

  // frame config fields: source in [1:0], slice count in [12:8]
  localparam int unsigned FCFG_SRC_LSB   = 0;
  localparam int unsigned FCFG_SLICE_LSB = 8;
  localparam int unsigned SLICE_W        = 5;

  // ============================================================
  // reset values
  localparam logic [31:0] THRESH_RST    = 32'h0000_0000;
  localparam logic [31:0] RST_DELAY_RST = 32'h0000_1000;
  localparam logic [31:0] ROI_LIMIT_RST = 32'h0000_0040;
  localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;
  localparam logic [31:0] FRAME_CFG_RST = 32'h0000_0100;

  // ============================================================
  // counter widths
  localparam int unsigned EVENT_NUM_W = 24;
  localparam int unsigned TALLY_W     = 8;

  // ============================================================
  // input frame figures per timeslice
  localparam logic [19:0] LEN_CLUSTER  = 20'h0_0054; // 84 ticks
  localparam logic [19:0] LEN_JET      = 20'h0_0043; // 67 ticks
  localparam logic [19:0] LEN_MERGER   = 20'h0_0023; // 35 ticks
  localparam logic [19:0] LEN_PREPROC  = 20'h0_0114; // 276 ticks
  localparam logic [19:0] LINES_JET    = 20'h0_0010; // 16 data lines
  localparam logic [19:0] LINES_OTHER  = 20'h0_0014; // 20 data lines
  localparam logic [19:0] PARITY_BITS  = 20'h0_0014; // 20, sent once
  localparam logic [19:0] JET_UNUSED_A = 20'h0_0016; // 22 on one line
  localparam logic [19:0] JET_UNUSED_B = 20'h0_0004; // 4 on the next

  typedef enum logic [1:0] {
    SRC_CLUSTER,
    SRC_JET,
    SRC_MERGER,
    SRC_PREPROC
  } source_t;

  // ============================================================
  // event header fields handed to the output link
  typedef struct packed {
    logic [EVENT_NUM_W-1:0] event_number;
    logic [TALLY_W-1:0]     tally;
    logic                   data_loss;
  } header_fields_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } roi_word_t;

endpackage
`default_nettype wire

// *** design/busy_compare.sv ***
`default_nettype none
// ============================================================
// per-buffer depth compare against the busy threshold
module busy_compare #(
  parameter int unsigned NBUF    = 18,
  parameter int unsigned DEPTH_W = 12
) (
  // buffer depths, buffer 0 in the low bits
  input  wire logic [NBUF*DEPTH_W-1:0] i_depth,
  input  wire logic [DEPTH_W-1:0]      i_thresh,
  // result
  output logic                         o_over_any,
  output logic                         o_all_empty
);

  logic [NBUF-1:0] over;
  logic [NBUF-1:0] empty;

  // one comparator per buffer; an empty buffer never counts
  genvar g;
  generate
    for (g = 0; g < NBUF; g++)
    begin : g_buf
      assign empty[g] = (i_depth[g*DEPTH_W +: DEPTH_W] == '0);
      assign over[g]  = !empty[g]
        && (i_depth[g*DEPTH_W +: DEPTH_W] > i_thresh);
    end
  endgenerate

  assign o_over_any  = |over;
  assign o_all_empty = &empty;

endmodule
`default_nettype wire

// *** design/readout_ctl.sv ***
`default_nettype none
// Summary of operation
// - busy when any buffer depth exceeds threshold
// - busy drops once all depths at/below threshold
// - empty buffers never raise busy
// - threshold equal to depth disables busy
// - busy pin feeds the trigger processor chain
// - on overflow, header flags the data loss
// - clear pulses tallied into eight-bit header field
// - own 24-bit accept count, zeroed by clear
// - header carries the accept count
// - delayed buffer reset after a clear pulse; a second pulse restarts the delay
// - region records over limit end, status flagged
// - excess records dropped in arrival order
// - expected frame lengths per source module
// - parity bits counted once per frame
// - jet frames skip 22 and 4 bits
module readout_ctl #(
  parameter int unsigned NBUF          = 18,
  parameter int unsigned DEPTH_W       = 12,
  parameter int unsigned PHYS_DEPTH    = 2048,
  parameter int unsigned BUF_RESET_MAX = readout_ctl_pkg::BUF_RESET_MAX_CYC
) (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_resetn,
  // axi4-lite register slave
  input  wire logic [7:0]             i_s_axi_awaddr,
  input  wire logic                   i_s_axi_awvalid,
  output logic                        o_s_axi_awready,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  input  wire logic                   i_s_axi_wvalid,
  output logic                        o_s_axi_wready,
  output logic [1:0]                  o_s_axi_bresp,
  output logic                        o_s_axi_bvalid,
  input  wire logic                   i_s_axi_bready,
  input  wire logic [7:0]             i_s_axi_araddr,
  input  wire logic                   i_s_axi_arvalid,
  output logic                        o_s_axi_arready,
  output logic [31:0]                 o_s_axi_rdata,
  output logic [1:0]                  o_s_axi_rresp,
  output logic                        o_s_axi_rvalid,
  input  wire logic                   i_s_axi_rready,
  // trigger pins, asynchronous
  input  wire logic                   i_first_level_accept,
  input  wire logic                   i_event_count_clear_pulse,
  output logic                        o_busy_pin,
  // input buffer state
  input  wire logic [NBUF*DEPTH_W-1:0] i_buf_depth,
  input  wire logic [NBUF-1:0]        i_buf_overflow,
  output logic                        o_buffer_reset,
  // event header
  input  wire logic                   i_event_done,
  output readout_ctl_pkg::header_fields_t o_header,
  // region record stream
  input  wire logic                   i_roi_start,
  input  wire readout_ctl_pkg::roi_word_t i_roi,
  output readout_ctl_pkg::roi_word_t  o_roi,
  output logic                        o_roi_truncated,
  // interrupt
  output logic                        o_irq
);

  localparam int unsigned DLY_W = $clog2(BUF_RESET_MAX + 1);
  localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(BUF_RESET_MAX);
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = DEPTH_W'(PHYS_DEPTH);
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ST_IDLE, ST_WAIT} rst_state_t;

  // ============================================================
  // pin synchronisers: meta stage feeds only the sync stage
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;
  wire  [1:0] pin_rise = pin_sync_reg & ~pin_prev_reg;
  wire        accept_evt = pin_rise[0];
  wire        clear_evt  = pin_rise[1];

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      pin_meta_reg <= 2'b00;
      pin_sync_reg <= 2'b00;
      pin_prev_reg <= 2'b00;
    end
    else
    begin
      pin_meta_reg <= {i_event_count_clear_pulse, i_first_level_accept};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ============================================================
  // register file
  localparam int unsigned IRQ_W_L = readout_ctl_pkg::IRQ_W;
  logic [31:0]          thresh_reg;
  logic [31:0]          delay_reg;
  logic [31:0]          roi_limit_reg;
  logic [31:0]          frame_cfg_reg;
  logic [IRQ_W_L-1:0]   irq_stat_reg;
  logic [IRQ_W_L-1:0]   irq_mask_reg;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    return res;
  endfunction

  // ============================================================
  // axi4-lite write channel: address and data taken in any order
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  wire aw_fire  = i_s_axi_awvalid && awready_reg;
  wire w_fire   = i_s_axi_wvalid && wready_reg;
  wire b_fire   = bvalid_reg && i_s_axi_bready;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_known = (awaddr_reg <= readout_ctl_pkg::OFS_FRAME_LEN)
                  && (awaddr_reg[1:0] == 2'b00);
  wire wr_thr   = do_write && awaddr_reg == readout_ctl_pkg::OFS_THRESH;
  wire wr_dly   = do_write && awaddr_reg == readout_ctl_pkg::OFS_RST_DELAY;
  wire wr_lim   = do_write && awaddr_reg == readout_ctl_pkg::OFS_ROI_LIMIT;
  wire wr_stat  = do_write && awaddr_reg == readout_ctl_pkg::OFS_IRQ_STAT;
  wire wr_mask  = do_write && awaddr_reg == readout_ctl_pkg::OFS_IRQ_MASK;
  wire wr_fcfg  = do_write && awaddr_reg == readout_ctl_pkg::OFS_FRAME_CFG;
  wire [31:0] wr_w1c = merge(32'h0000_0000, wdata_reg, wstrb_reg);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= i_s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (w_fire)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= i_s_axi_wdata;
        wstrb_reg  <= i_s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      // one write in flight: both channels reopen after the response
      if (b_fire)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ============================================================
  // counters, busy, loss and buffer reset sequencing
  localparam int unsigned EVW = readout_ctl_pkg::EVENT_NUM_W;
  localparam int unsigned TW  = readout_ctl_pkg::TALLY_W;
  logic                   busy_reg;
  logic [EVW-1:0]         event_num_reg;
  logic [TW-1:0]          tally_reg;
  logic                   loss_reg;
  rst_state_t             rst_state_reg;
  logic [DLY_W-1:0]       rst_cnt_reg;
  logic                   buf_reset_reg;

  logic over_any;
  logic all_empty;

  busy_compare #(
    .NBUF    (NBUF),
    .DEPTH_W (DEPTH_W)
  ) u_busy_compare (
    .i_depth     (i_buf_depth),
    .i_thresh    (thresh_reg[DEPTH_W-1:0]),
    .o_over_any  (over_any),
    .o_all_empty (all_empty)
  );

  // delay clamped below the limit; the reset comes dly_load+2 cycles after clear_evt
  wire [DLY_W-1:0] dly_load = (delay_reg > 32'(BUF_RESET_MAX))
                              ? DLY_MAX : delay_reg[DLY_W-1:0];
  wire overflow_any = |i_buf_overflow;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      busy_reg      <= 1'b0;
      event_num_reg <= '0;
      tally_reg     <= '0;
      loss_reg      <= 1'b0;
      rst_state_reg <= ST_IDLE;
      rst_cnt_reg   <= '0;
      buf_reset_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= over_any;
      if (clear_evt)
      begin
        tally_reg     <= tally_reg + 1'b1;
        event_num_reg <= '0;
      end
      else if (accept_evt)
        event_num_reg <= event_num_reg + 1'b1;
      // new overflow wins over the end-of-event clear
      if (overflow_any)
        loss_reg <= 1'b1;
      else if (i_event_done || buf_reset_reg)
        loss_reg <= 1'b0;
      buf_reset_reg <= 1'b0;
      case (rst_state_reg)
        ST_IDLE:
        begin
          if (clear_evt)
          begin
            rst_state_reg <= ST_WAIT;
            rst_cnt_reg   <= dly_load;
          end
        end
        ST_WAIT:
        begin
          // a second clear pulse restarts the interval
          if (clear_evt)
            rst_cnt_reg <= dly_load;
          else if (rst_cnt_reg == '0)
          begin
            buf_reset_reg <= 1'b1;
            rst_state_reg <= ST_IDLE;
          end
          else
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
        end
        default: rst_state_reg <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // region record limiter: no sorting, later records just dropped
  logic [31:0] roi_cnt_reg;
  logic        trunc_reg;
  readout_ctl_pkg::roi_word_t roi_out_reg;
  wire roi_over = i_roi.valid && (roi_cnt_reg >= roi_limit_reg);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      roi_cnt_reg <= 32'h0000_0000;
      trunc_reg   <= 1'b0;
      roi_out_reg <= '0;
    end
    else
    begin
      roi_out_reg.data  <= i_roi.data;
      roi_out_reg.valid <= i_roi.valid && !roi_over;
      if (i_roi_start)
      begin
        roi_cnt_reg <= 32'h0000_0000;
        trunc_reg   <= 1'b0;
      end
      else if (i_roi.valid)
      begin
        if (roi_over)
          trunc_reg <= 1'b1;
        else
          roi_cnt_reg <= roi_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ============================================================
  // expected input frame size in active bits
  wire readout_ctl_pkg::source_t fsrc = readout_ctl_pkg::source_t'(
    frame_cfg_reg[readout_ctl_pkg::FCFG_SRC_LSB +: 2]);
  wire [19:0] slices = 20'(
    frame_cfg_reg[readout_ctl_pkg::FCFG_SLICE_LSB +:
                  readout_ctl_pkg::SLICE_W]);
  wire [19:0] slice_len =
    (fsrc == readout_ctl_pkg::SRC_CLUSTER) ? readout_ctl_pkg::LEN_CLUSTER :
    (fsrc == readout_ctl_pkg::SRC_JET)     ? readout_ctl_pkg::LEN_JET :
    (fsrc == readout_ctl_pkg::SRC_MERGER)  ? readout_ctl_pkg::LEN_MERGER :
                                             readout_ctl_pkg::LEN_PREPROC;
  wire [19:0] lines = (fsrc == readout_ctl_pkg::SRC_JET)
                      ? readout_ctl_pkg::LINES_JET
                      : readout_ctl_pkg::LINES_OTHER;
  wire [19:0] unused = (fsrc == readout_ctl_pkg::SRC_JET)
    ? 20'(readout_ctl_pkg::JET_UNUSED_A + readout_ctl_pkg::JET_UNUSED_B)
    : 20'h0_0000;
  wire [19:0] per_slice = 20'(slice_len * lines) - unused;
  // parity word only on the last slice, so strip it from the others
  wire [19:0] frame_bits = (slices == 20'h0_0000) ? 20'h0_0000
    : 20'(slices * per_slice)
      - 20'((slices - 20'h0_0001) * readout_ctl_pkg::PARITY_BITS);

  // ============================================================
  // interrupt status: hardware set beats a write-one clear
  wire [IRQ_W_L-1:0] irq_set = {clear_evt, trunc_reg == 1'b0 && roi_over,
                                overflow_any, over_any && !busy_reg};
  logic irq_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      thresh_reg    <= readout_ctl_pkg::THRESH_RST;
      delay_reg     <= readout_ctl_pkg::RST_DELAY_RST;
      roi_limit_reg <= readout_ctl_pkg::ROI_LIMIT_RST;
      frame_cfg_reg <= readout_ctl_pkg::FRAME_CFG_RST;
      irq_mask_reg  <= IRQ_W_L'(readout_ctl_pkg::IRQ_MASK_RST);
      irq_stat_reg  <= '0;
      irq_reg       <= 1'b0;
    end
    else
    begin
      if (wr_thr)
        thresh_reg <= merge(thresh_reg, wdata_reg, wstrb_reg);
      if (wr_dly)
        delay_reg <= merge(delay_reg, wdata_reg, wstrb_reg);
      if (wr_lim)
        roi_limit_reg <= merge(roi_limit_reg, wdata_reg, wstrb_reg);
      if (wr_fcfg)
        frame_cfg_reg <= merge(frame_cfg_reg, wdata_reg, wstrb_reg);
      if (wr_mask)
        irq_mask_reg <= wdata_reg[IRQ_W_L-1:0];
      irq_stat_reg <= (irq_stat_reg
                       & ~(wr_stat ? wr_w1c[IRQ_W_L-1:0] : '0)) | irq_set;
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ============================================================
  // read channel: answer one cycle after the address is taken
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  wire  [7:0]  ra = i_s_axi_araddr;
  wire  [31:0] status_word = {28'h000_0000, 1'b0, trunc_reg,
                              loss_reg, busy_reg};
  wire  rd_hit = (ra <= readout_ctl_pkg::OFS_FRAME_LEN) && (ra[1:0] == 2'b00);
  wire [31:0] rd_mux =
    (ra == readout_ctl_pkg::OFS_THRESH)    ? thresh_reg :
    (ra == readout_ctl_pkg::OFS_STATUS)    ? status_word :
    (ra == readout_ctl_pkg::OFS_EVENT_NUM) ? 32'(event_num_reg) :
    (ra == readout_ctl_pkg::OFS_TALLY)     ? 32'(tally_reg) :
    (ra == readout_ctl_pkg::OFS_RST_DELAY) ? delay_reg :
    (ra == readout_ctl_pkg::OFS_ROI_LIMIT) ? roi_limit_reg :
    (ra == readout_ctl_pkg::OFS_IRQ_STAT)  ? 32'(irq_stat_reg) :
    (ra == readout_ctl_pkg::OFS_IRQ_MASK)  ? 32'(irq_mask_reg) :
    (ra == readout_ctl_pkg::OFS_FRAME_CFG) ? frame_cfg_reg :
    (ra == readout_ctl_pkg::OFS_FRAME_LEN) ? 32'(frame_bits) :
                                             32'h0000_0000;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_resetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end
    else if (i_s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && i_s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ============================================================
  // outputs, all from flip-flops
  assign o_s_axi_awready     = awready_reg;
  assign o_s_axi_wready      = wready_reg;
  assign o_s_axi_bvalid      = bvalid_reg;
  assign o_s_axi_bresp       = bresp_reg;
  assign o_s_axi_arready     = arready_reg;
  assign o_s_axi_rvalid      = rvalid_reg;
  assign o_s_axi_rdata       = rdata_reg;
  assign o_s_axi_rresp       = rresp_reg;
  assign o_busy_pin          = busy_reg;
  assign o_buffer_reset      = buf_reset_reg;
  assign o_header            = {event_num_reg,
                                tally_reg,
                                loss_reg};
  assign o_roi               = roi_out_reg;
  assign o_roi_truncated     = trunc_reg;
  assign o_irq               = irq_reg;

  // ============================================================
  // checks
  busy_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    over_any |=> o_busy_pin) else $error("busy not raised");
  busy_drop_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    !over_any [*2] |-> !o_busy_pin) else $error("busy held");
  empty_quiet_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    all_empty |=> !o_busy_pin) else $error("busy while empty");
  full_thresh_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    thresh_reg[DEPTH_W-1:0] == DEPTH_FULL |=> !o_busy_pin)
    else $error("busy at full threshold");
  tally_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    clear_evt |=> o_header.tally == $past(tally_reg) + 8'h01)
    else $error("tally not stepped");
  event_clear_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_resetn)
    clear_evt |=> o_header.event_number == '0)
    else $error("event number not cleared");
  event_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    accept_evt && !clear_evt |=>
      o_header.event_number == EVW'($past(event_num_reg) + 1'b1))
    else $error("event number not stepped");
  buf_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    clear_evt && rst_state_reg == ST_IDLE && dly_load == '0
      |-> ##2 o_buffer_reset) else $error("buffer reset late");
  roi_cut_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    roi_over && !i_roi_start |=> !o_roi.valid && o_roi_truncated)
    else $error("record passed limit");
  loss_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    overflow_any |=> o_header.data_loss) else $error("loss unflagged");

endmodule
`default_nettype wire

// *** dv/trig_partner.sv ***
`default_nettype none
// ============================================================
// trigger processor stand-in driving the two trigger pins
module trig_partner
(
  // requests from the bench
  input  wire logic i_clk_sys,
  input  wire logic i_fire_accept,
  input  wire logic i_fire_clear,
  // trigger pins
  output logic      o_accept,
  output logic      o_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] acc_cnt = 3'h0;
  logic [2:0] clr_cnt = 3'h0;
  // three cycles high, as one-cycle pins slip past the synchronisers
  always_ff @(posedge i_clk_sys)
  begin
    acc_cnt <= i_fire_accept ? 3'h3 : acc_cnt - 3'(acc_cnt != 3'h0);
    clr_cnt <= i_fire_clear ? 3'h3 : clr_cnt - 3'(clr_cnt != 3'h0);
  end
  assign o_accept = (acc_cnt != 3'h0);
  assign o_clear  = (clr_cnt != 3'h0);
endmodule
`default_nettype wire

// *** dv/readout_busy_and_event_count_control_bench.sv ***
`default_nettype none
// ============================================================
// self-checking bench, seeded random with corner cases
module readout_busy_and_event_count_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic fa = 0, fc = 0, done = 0, rs = 0, acc, clr, awr, wrd, bv, arr, rv;
  logic brst, trunc, irq, busy;
  logic [7:0] awa = 0, ara = 0;
  logic [1:0] bresp, rsp;
  logic [31:0] wd = 0, rdat, v, d, ed, lastd, rng = 32'h0000_CECC;
  logic [215:0] dep = 0;
  logic [17:0] ovf = 0;
  readout_ctl_pkg::header_fields_t hdr;
  readout_ctl_pkg::roi_word_t ri = 0, ro;
  int num_errors = 0, num_checks = 0, k, n, nrst = 0, nroi = 0;
  always #2.5 clk = ~clk;
  readout_ctl #(.BUF_RESET_MAX(20)) readout_ctl_inst (.i_clk_sys(clk),
    .i_resetn(rstn), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdat),
    .o_s_axi_rresp(rsp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr),
    .i_first_level_accept(acc), .i_event_count_clear_pulse(clr),
    .o_busy_pin(busy), .i_buf_depth(dep), .i_buf_overflow(ovf),
    .o_buffer_reset(brst), .i_event_done(done), .o_header(hdr),
    .i_roi_start(rs), .i_roi(ri), .o_roi(ro), .o_roi_truncated(trunc),
    .o_irq(irq));
  trig_partner trig_partner_inst (.i_clk_sys(clk), .i_fire_accept(fa),
    .i_fire_clear(fc), .o_accept(acc), .o_clear(clr));
  // pulse and record tallies seen at the outputs
  always @(posedge clk)
  begin
    if (brst === 1'b1) nrst++;
    if (ro.valid === 1'b1) {nroi, lastd} = {nroi + 1, ro.data};
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // active bits: parity sent once, jet frames lose 26 bits per slice
  function automatic int flen(int s, int n);
    int l[4] = '{84, 67, 35, 276};
    return n * (l[s] * (s == 1 ? 16 : 20) - (s == 1 ? 26 : 0)) - (n - 1) * 20;
  endfunction
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic [2:0] p = 3'h7;
    @(posedge clk);
    {awa, wd, awv, wv, br} <= {a, x, p};
    while (p[0])
    begin
      @(posedge clk);
      p = p & ~{awr, wrd, bv};
      {awv, wv, br} <= p;
    end
  endtask
  // read data taken at the edge where rvalid is seen high
  task automatic rd(input logic [7:0] a);
    logic [1:0] p = 2'h3;
    @(posedge clk);
    {ara, arv, rr} <= {a, p};
    while (p[0])
    begin
      @(posedge clk);
      if (rv) v = rdat;
      p = p & ~{arr, rv};
      {arv, rr} <= p;
    end
  endtask
  task automatic fire(input logic c);
    {fc, fa} <= {c, !c};
    @(posedge clk);
    {fc, fa} <= 2'h0;
    repeat (9) @(posedge clk);
  endtask
  task automatic bz(input logic [11:0] t, x, input logic e);
    wr(8'h00, {20'h0_0000, t});
    dep <= 216'(x) << (12 * (xs() % 18));
    repeat (4) @(posedge clk);
    chk(busy, e);
    rd(8'h04);
    chk(v[0], e);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(8'h30);
    chk(rsp, 32'h0000_0002);
    wr(8'h30, 32'h0000_0001);
    chk(bresp, 32'h0000_0002);
    n = 1 + xs() % 2000;
    bz(12'(n), 12'(n + 1), 1);
    bz(12'(n), 12'(n), 0);
    bz(12'h000, 12'h000, 0);
    bz(12'h800, 12'h800, 0);
    wr(8'h10, 32'h0000_0005);
    wr(8'h1C, 32'h0000_0008);
    n = 1 + xs() % 6;
    repeat (n) fire(0);
    chk(hdr.event_number, n);
    fire(1);
    repeat (30) @(posedge clk);
    chk(hdr.event_number, 0);
    chk(hdr.tally, 1);
    chk(nrst, 1);
    chk(irq, 1);
    wr(8'h18, 32'h0000_000F);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    repeat (255) fire(1);
    chk(hdr.tally, 0);
    wr(8'h10, 32'h0000_0000);
    n = nrst;
    fire(1);
    chk(nrst, n + 1);
    for (k = 0; k < 4; k++)
    begin
      n = 1 + xs() % 31;
      wr(8'h20, 32'((n << 8) | k));
      rd(8'h24);
      chk(v, 32'(flen(k, n)));
    end
    wr(8'h14, 32'h0000_0003);
    rs <= 1;
    for (k = 0; k < 5; k++)
    begin
      @(posedge clk);
      d = xs();
      rs <= 0;
      ri <= {1'b1, d};
      if (k == 2) ed = d;
    end
    @(posedge clk);
    ri <= 0;
    repeat (3) @(posedge clk);
    chk(nroi, 3);
    chk(lastd, ed);
    chk(trunc, 1);
    ovf <= 18'h0_0004;
    @(posedge clk);
    ovf <= 0;
    repeat (2) @(posedge clk);
    chk(hdr.data_loss, 1);
    rd(8'h04);
    chk(v[2:1], 32'h0000_0003);
    done <= 1;
    @(posedge clk);
    done <= 0;
    repeat (2) @(posedge clk);
    chk(hdr.data_loss, 0);
    close_out();
  end
endmodule
`default_nettype wire
